/* File: design/hcra_defs.vh */
`ifndef HCRA_DEFS_VH
`define HCRA_DEFS_VH

// register indices, byte address is four times the index
`define HCRA_IDX_PAGE_SEL     5'h00
`define HCRA_IDX_CFG_A        5'h0A
`define HCRA_IDX_RBC0_RB      5'h1E
`define HCRA_IDX_STATUS       5'h1F
`define HCRA_PAGE0            2'h0

// mode configuration register a fields
`define HCRA_CFG_RES_BIT      7
`define HCRA_CFG_FE_BIT       6
`define HCRA_CFG_IRQ_MSB      5
`define HCRA_CFG_IRQ_LSB      3
`define HCRA_CFG_IO_MSB       2
`define HCRA_CFG_IO_LSB       0
`define HCRA_CFG_A_RESET      8'h00
`define HCRA_CFG_WR_MASK      8'h7F

// io window selections and bases
`define HCRA_SEL_SOFTWARE     3'h1
`define HCRA_BASE_000         10'h300
`define HCRA_BASE_010         10'h240
`define HCRA_BASE_011         10'h280
`define HCRA_BASE_100         10'h2C0
`define HCRA_BASE_101         10'h320
`define HCRA_BASE_110         10'h340
`define HCRA_BASE_111         10'h360
`define HCRA_WIN_LSBS         5

// software configuration port
`define HCRA_SW_PORT_ADDR     10'h278
`define HCRA_SW_WRITES        3'h4

// ahb
`define HCRA_HTRANS_NONSEQ    2'h2
`define HCRA_HRESP_OKAY       1'b0

`endif

/* File: design/hcra_sw_seq.v */
`timescale 1ns/1ns
`default_nettype none
`include "hcra_defs.vh"

module hcra_sw_seq (
	input  wire       ref_clk,
	input  wire       rst,
	input  wire       wr_pulse,
	input  wire [9:0] wr_addr,
	input  wire [2:0] wr_data,
	input  wire       sel_is_sw,
	output wire       load,
	output reg  [2:0] load_data_ff,
	output reg        used_ff
);

	reg  [2:0] cnt_ff;
	reg  [2:0] nxt_cnt;
	reg        load_ff;
	wire       port_hit;
	wire       last;

	assign port_hit = wr_pulse && (wr_addr == `HCRA_SW_PORT_ADDR);
	assign last     = port_hit && (cnt_ff == `HCRA_SW_WRITES - 3'h1);
	assign load     = load_ff;

	// any other host write breaks the run of consecutive writes
	always @* begin
		nxt_cnt = cnt_ff;
		if (wr_pulse) begin
			if (port_hit && !last)
				nxt_cnt = cnt_ff + 3'h1;
			else
				nxt_cnt = 3'h0;
		end
	end

	always @(posedge ref_clk) begin
		if (rst) begin
			cnt_ff       <= 3'h0;
			load_ff      <= 1'b0;
			load_data_ff <= 3'h0;
			used_ff      <= 1'b0;
		end else begin
			load_ff <= 1'b0;
			if (sel_is_sw && !used_ff) begin
				cnt_ff <= nxt_cnt;
				if (last) begin
					load_ff      <= 1'b1;
					load_data_ff <= wr_data;
					used_ff      <= 1'b1;
				end
			end else begin
				cnt_ff <= 3'h0;
			end
		end
	end

endmodule
`default_nettype wire

/* File: design/hcra_top.v */
// Contract
// - page0 read 0AH returns config register
// - 0AH write updates config only after read
// - otherwise page0 0AH write goes to count0
// - bit7 reserved, fe option, irq, io select
// - io select maps 20H window base
// - select 001: ignore io, 278H sequence once
`timescale 1ns/1ns
`default_nettype none
`include "hcra_defs.vh"

module hcra_top (
	input  wire        ref_clk,
	input  wire        rst,
	input  wire        hsel,
	input  wire [31:0] haddr,
	input  wire [1:0]  htrans,
	input  wire        hwrite,
	input  wire [2:0]  hsize,
	input  wire [31:0] hwdata,
	input  wire        hready,
	output wire        hreadyout,
	output wire        hresp,
	output reg  [31:0] hrdata_ff,
	input  wire [9:0]  io_addr_pin,
	input  wire [2:0]  io_data_pin,
	input  wire        io_wr_n_pin,
	output reg         io_hit_ff,
	output reg  [9:0]  io_base_ff,
	output wire        front_end_rw_option,
	output wire [2:0]  irq_line_select,
	output wire [2:0]  io_window_select,
	output wire [7:0]  remote_byte_count0
);

	reg  [7:0]  cfg_a_ff;
	reg  [7:0]  rbc0_ff;
	reg  [1:0]  page_ff;
	reg         pend_ff;
	reg         dp_act_ff;
	reg         dp_wr_ff;
	reg         dp_wait_ff;
	reg  [4:0]  dp_idx_ff;
	reg  [31:0] nxt_rdata;
	reg  [9:0]  addr_s1_ff;
	reg  [9:0]  addr_s2_ff;
	reg  [2:0]  data_s1_ff;
	reg  [2:0]  data_s2_ff;
	reg         wr_s1_ff;
	reg         wr_s2_ff;
	reg         wr_s3_ff;
	wire        ap_take;
	wire        dp_done;
	wire        is_cfg_idx;
	wire        cfg_wr_ok;
	wire        host_wr_pulse;
	wire        sel_is_sw;
	wire        seq_load;
	wire [2:0]  seq_data;
	wire        seq_used;
	wire [9:0]  cur_base;

	// base of the 20H window for each select code other than 001
	function [9:0] win_base;
		input [2:0] sel;
		begin
			case (sel)
				3'h0:    win_base = `HCRA_BASE_000;
				3'h2:    win_base = `HCRA_BASE_010;
				3'h3:    win_base = `HCRA_BASE_011;
				3'h4:    win_base = `HCRA_BASE_100;
				3'h5:    win_base = `HCRA_BASE_101;
				3'h6:    win_base = `HCRA_BASE_110;
				3'h7:    win_base = `HCRA_BASE_111;
				default: win_base = 10'h000;
			endcase
		end
	endfunction

	// ahb: writes finish without wait, reads take one wait state
	// hsize not decoded: only whole-word transfers are supported
	assign ap_take    = hsel && hready && (htrans == `HCRA_HTRANS_NONSEQ);
	assign dp_done    = dp_act_ff && !(dp_wait_ff && !dp_wr_ff);
	assign hreadyout  = !(dp_act_ff && !dp_wr_ff && dp_wait_ff);
	assign hresp      = `HCRA_HRESP_OKAY;
	assign is_cfg_idx = (dp_idx_ff == `HCRA_IDX_CFG_A) && (page_ff == `HCRA_PAGE0);
	assign cfg_wr_ok  = dp_wr_ff && is_cfg_idx && pend_ff;

	assign front_end_rw_option = cfg_a_ff[`HCRA_CFG_FE_BIT];
	assign irq_line_select     = cfg_a_ff[`HCRA_CFG_IRQ_MSB:`HCRA_CFG_IRQ_LSB];
	assign io_window_select    = cfg_a_ff[`HCRA_CFG_IO_MSB:`HCRA_CFG_IO_LSB];
	assign remote_byte_count0  = rbc0_ff;
	assign sel_is_sw           = (io_window_select == `HCRA_SEL_SOFTWARE);
	// looked up once; the software select maps to no window at all
	assign cur_base            = win_base(io_window_select);

	always @(posedge ref_clk) begin
		if (rst) begin
			dp_act_ff  <= 1'b0;
			dp_wr_ff   <= 1'b0;
			dp_wait_ff <= 1'b0;
			dp_idx_ff  <= 5'h00;
		end else begin
			if (ap_take) begin
				dp_act_ff  <= 1'b1;
				dp_wr_ff   <= hwrite;
				dp_wait_ff <= 1'b1;
				dp_idx_ff  <= haddr[6:2];
			end else if (hready || dp_done) begin
				dp_act_ff  <= 1'b0;
				dp_wait_ff <= 1'b0;
			end else begin
				dp_wait_ff <= 1'b0;
			end
		end
	end

	// unmapped indices read as zero so software sees no stale data
	always @* begin
		nxt_rdata = 32'h0000_0000;
		case (dp_idx_ff)
			`HCRA_IDX_PAGE_SEL: nxt_rdata = {30'h0000_0000, page_ff};
			`HCRA_IDX_CFG_A: begin
				if (page_ff == `HCRA_PAGE0)
					nxt_rdata = {24'h00_0000, 1'b0, cfg_a_ff[6:0]};
			end
			`HCRA_IDX_RBC0_RB: nxt_rdata = {24'h00_0000, rbc0_ff};
			`HCRA_IDX_STATUS:  nxt_rdata = {29'h0000_0000, seq_used, sel_is_sw, pend_ff};
			default:           nxt_rdata = 32'h0000_0000;
		endcase
	end

	// read data sampled in the wait cycle, after any earlier write landed
	always @(posedge ref_clk) begin
		if (rst)
			hrdata_ff <= 32'h0000_0000;
		else if (dp_act_ff && !dp_wr_ff && dp_wait_ff)
			hrdata_ff <= nxt_rdata;
	end

	// the unlock lives exactly one access; a page switch also relocks
	always @(posedge ref_clk) begin
		if (rst) begin
			pend_ff <= 1'b0;
		end else if (dp_done) begin
			pend_ff <= !dp_wr_ff && is_cfg_idx;
		end
	end

	// reserved bit held at zero so it always reads back clear
	always @(posedge ref_clk) begin
		if (rst) begin
			cfg_a_ff <= `HCRA_CFG_A_RESET;
			rbc0_ff  <= 8'h00;
			page_ff  <= `HCRA_PAGE0;
		end else begin
			if (dp_done && dp_wr_ff) begin
				// a page switch is an access too, so it relocks the write
				if (dp_idx_ff == `HCRA_IDX_PAGE_SEL)
					page_ff <= hwdata[1:0];
				if (cfg_wr_ok)
					cfg_a_ff <= hwdata[7:0] & `HCRA_CFG_WR_MASK;
				else if (is_cfg_idx)
					rbc0_ff <= hwdata[7:0];
			end
			// host sequence load takes the select field over a bus write
			if (seq_load)
				cfg_a_ff[`HCRA_CFG_IO_MSB:`HCRA_CFG_IO_LSB] <= seq_data;
		end
	end

	// io pins: two flops before use, third flop only for edge detect
	always @(posedge ref_clk) begin
		if (rst) begin
			addr_s1_ff <= 10'h000;
			addr_s2_ff <= 10'h000;
			data_s1_ff <= 3'h0;
			data_s2_ff <= 3'h0;
			wr_s1_ff   <= 1'b0;
			wr_s2_ff   <= 1'b0;
			wr_s3_ff   <= 1'b0;
		end else begin
			addr_s1_ff <= io_addr_pin;
			addr_s2_ff <= addr_s1_ff;
			data_s1_ff <= io_data_pin;
			data_s2_ff <= data_s1_ff;
			wr_s1_ff   <= !io_wr_n_pin;
			wr_s2_ff   <= wr_s1_ff;
			wr_s3_ff   <= wr_s2_ff;
		end
	end

	// strobe edge; address and data must settle before the strobe
	assign host_wr_pulse = wr_s2_ff && !wr_s3_ff;

	always @(posedge ref_clk) begin
		if (rst) begin
			io_hit_ff  <= 1'b0;
			io_base_ff <= 10'h000;
		end else begin
			io_base_ff <= cur_base;
			io_hit_ff  <= !sel_is_sw &&
				(addr_s2_ff[9:`HCRA_WIN_LSBS] == cur_base[9:`HCRA_WIN_LSBS]);
		end
	end

	// the host sequence counts only while the window is parked on 001
	hcra_sw_seq u_sw_seq (
		.ref_clk      (ref_clk),
		.rst          (rst),
		.wr_pulse     (host_wr_pulse),
		.wr_addr      (addr_s2_ff),
		.wr_data      (data_s2_ff),
		.sel_is_sw    (sel_is_sw),
		.load         (seq_load),
		.load_data_ff (seq_data),
		.used_ff      (seq_used)
	);

endmodule
`default_nettype wire

/* File: sim/hcra_top_sva.sv */
`timescale 1ns/1ns
`default_nettype none
module hcra_chk (
	input wire logic        ref_clk,
	input wire logic        rst,
	input wire logic        hsel,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic        hready,
	input wire logic        hreadyout,
	input wire logic        hresp,
	input wire logic [31:0] hrdata_ff,
	input wire logic [9:0]  io_base_ff,
	input wire logic        front_end_rw_option,
	input wire logic [2:0]  irq_line_select,
	input wire logic [2:0]  io_window_select,
	input wire logic [7:0]  remote_byte_count0
);
	localparam logic [9:0] B [8] = '{10'h300, 10'h000, 10'h240, 10'h280,
		10'h2C0, 10'h320, 10'h340, 10'h360};
	wire rd = hsel && hready && htrans == 2'h2 && !hwrite;
	wire wr = hsel && hready && htrans == 2'h2 && hwrite;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	a_resp_okay: assert property (hresp == 1'b0) else $error("bad hresp");
	a_read_wait: assert property (rd |=> !hreadyout ##1 hreadyout) else $error("rd wait");
	a_write_nowait: assert property (wr |=> hreadyout) else $error("wr wait");
	a_rdata_cause: assert property ($changed(hrdata_ff) |-> $past(rd, 2))
		else $error("rdata moved");
	a_cfg_cause: assert property ($changed({front_end_rw_option, irq_line_select})
		|-> $past(wr, 2)) else $error("cfg moved");
	a_count_cause: assert property ($changed(remote_byte_count0) |-> $past(wr, 2))
		else $error("count moved");
	a_base_map: assert property ($stable(io_window_select)[*4]
		|-> io_base_ff == B[io_window_select]) else $error("base map");
	a_soft_load: assert property ($changed(io_window_select) && !$past(wr, 2)
		|-> $past(io_window_select) == 3'h1) else $error("select moved");
	cover property (rd ##2 wr);
	cover property ($changed(remote_byte_count0));
	cover property ($changed(io_window_select) && !$past(wr, 2));
endmodule
`default_nettype wire

/* File: sim/tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	logic        ref_clk = 0, rst = 1, hsel = 0, hwrite = 0, io_wr_n_pin = 1, rdph = 0;
	logic [31:0] haddr = 0, hwdata = 0;
	logic [1:0]  htrans = 0;
	logic [2:0]  io_data_pin = 0;
	logic [9:0]  io_addr_pin = 0;
	logic [7:0]  cfg, r;
	logic [31:0] expq [$];
	wire         hreadyout, hresp, io_hit_ff, front_end_rw_option;
	wire  [31:0] hrdata_ff;
	wire  [9:0]  io_base_ff;
	wire  [2:0]  irq_line_select, io_window_select;
	wire  [7:0]  remote_byte_count0;
	int          errors = 0, checked = 0;
	localparam logic [9:0] B [8] = '{10'h300, 10'h000, 10'h240, 10'h280,
		10'h2C0, 10'h320, 10'h340, 10'h360};
	always #25 ref_clk = ~ref_clk;
	hcra_top u_hcra_top (.ref_clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
		.hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata_ff, .io_addr_pin,
		.io_data_pin, .io_wr_n_pin, .io_hit_ff, .io_base_ff, .front_end_rw_option,
		.irq_line_select, .io_window_select, .remote_byte_count0);
	task chk(input string n, input logic [31:0] s, input logic [31:0] e);
		checked++;
		if (s !== e) begin
			errors++;
			$display("MISMATCH %s exp %h seen %h", n, e, s);
		end
	endtask
	task results;
		$display("checked %0d errors %0d", checked, errors);
		if (errors == 0 && checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// read results are matched in order against the queued notes
	always @(posedge ref_clk) begin
		if (rdph && hreadyout)
			chk("hrdata", hrdata_ff, expq.pop_front());
		if (hreadyout)
			rdph <= hsel && htrans == 2'h2 && !hwrite;
	end
	task rdy;
		int n;
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (!hreadyout && n < 20);
		if (!hreadyout) begin
			errors++;
			results;
		end
	endtask
	// for reads d is the expected word
	task bus(input logic w, input logic [4:0] i, input logic [31:0] d);
		hsel <= 1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {25'h0, i, 2'h0};
		rdy;
		htrans <= 2'h0;
		hwdata <= d;
		if (!w)
			expq.push_back(d);
		rdy;
	endtask
	task unlock(input logic [7:0] d);
		bus(0, 5'h0A, {24'h0, cfg});
		bus(1, 5'h0A, {24'h0, d});
		cfg = d & 8'h7F;
	endtask
	// pins are synced in, so hold address well around the strobe
	task pin(input logic [9:0] a, input logic [2:0] d);
		io_addr_pin <= a;
		io_data_pin <= d;
		repeat (4) @(posedge ref_clk);
		io_wr_n_pin <= 0;
		repeat (3) @(posedge ref_clk);
		io_wr_n_pin <= 1;
		repeat (8) @(posedge ref_clk);
	endtask
	initial begin
		void'($urandom(32'hc8a0d267));
		cfg = 0;
		repeat (12) @(posedge ref_clk);
		rst <= 0;
		@(posedge ref_clk);
		bus(0, 5'h0A, 0);
		bus(0, 5'h1E, 0);
		$display("test reset done");
		r = 8'($urandom);
		unlock({r[7:3], 3'h2});
		bus(0, 5'h0A, {24'h0, cfg});
		chk("fields", {front_end_rw_option, irq_line_select, io_window_select}, cfg[6:0]);
		$display("test unlock done");
		r = 8'($urandom);
		bus(0, 5'h0A, {24'h0, cfg});
		bus(0, 5'h1E, 0);
		bus(1, 5'h0A, {24'h0, r});
		bus(0, 5'h0A, {24'h0, cfg});
		bus(0, 5'h1E, {24'h0, r});
		bus(1, 5'h0A, {24'h0, ~r});
		@(posedge ref_clk);
		chk("count0", remote_byte_count0, {24'h0, ~r});
		$display("test relock done");
		bus(1, 5'h00, 32'h1);
		bus(0, 5'h00, 32'h1);
		bus(0, 5'h0A, 0);
		bus(1, 5'h0A, {24'h0, r});
		bus(1, 5'h00, 0);
		bus(0, 5'h1E, {24'h0, ~r});
		bus(0, 5'h0A, {24'h0, cfg});
		$display("test page done");
		for (int s = 0; s < 8; s++) begin
			if (s != 1) begin
				unlock({cfg[7:3], s[2:0]});
				pin(B[s] + 10'($urandom % 32), 0);
				chk("base", io_base_ff, B[s]);
				chk("hit", io_hit_ff, 1);
			end
		end
		pin(B[7] + 10'h20, 0);
		chk("miss", io_hit_ff, 0);
		$display("test window done");
		unlock({cfg[7:3], 3'h1});
		pin(10'h300, 0);
		chk("ignored", io_hit_ff, 0);
		repeat (4) pin(10'h278, 3'h3);
		cfg[2:0] = 3'h3;
		chk("soft sel", io_window_select, 3'h3);
		chk("soft base", io_base_ff, 10'h280);
		unlock({cfg[7:3], 3'h1});
		bus(0, 5'h1F, 32'h6);
		repeat (4) pin(10'h278, 3'h5);
		chk("once", io_window_select, 3'h1);
		$display("test soft config done");
		results;
	end
endmodule
bind hcra_top hcra_chk u_hcra_chk (.ref_clk, .rst, .hsel, .htrans, .hwrite, .hready,
	.hreadyout, .hresp, .hrdata_ff, .io_base_ff, .front_end_rw_option, .irq_line_select,
	.io_window_select, .remote_byte_count0);
`default_nettype wire
